// ### design/eid_alu.sv
/*
  Eight-bit arithmetic and logic unit of the decoder, purely combinational.
  Assumes the caller picks which of the flag outputs it keeps.
*/
`timescale 1ns/1ps
module eid_alu import eid_pkg::*; (
  input  wire eid_alu_op_t op,        // operation
  input  wire logic [7:0]  a,         // file or literal operand
  input  wire logic [7:0]  w,         // accumulator
  input  wire logic        cin,       // carry flag in
  input  wire logic [2:0]  bitSel,    // bit number for bit ops
  output logic      [7:0]  res,       // result
  output logic             cOut,      // carry / not-borrow out
  output logic             dcOut,     // nibble carry out
  output logic             zOut       // result is zero
);
  // add with carry in; returns {carry, digit carry, sum}
  function automatic logic [9:0] addc(input logic [7:0] x, input logic [7:0] y, input logic ci);
    logic [4:0] lo;
    logic [8:0] full;
    lo   = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    full = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    return {full[8], lo[4], full[7:0]};
  endfunction

  // subtraction adds the complement, so carry reads as not-borrow
  always_comb begin
    logic [9:0] s;
    s     = 10'h000;
    res   = a;
    cOut  = cin;
    dcOut = 1'b0;
    case (op)
      ALU_ADD:   s = addc(a, w, 1'b0);
      ALU_ADDC:  s = addc(a, w, cin);
      ALU_SUB:   s = addc(a, ~w, 1'b1);
      ALU_SUBB:  s = addc(a, ~w, cin);
      ALU_AND:   res = a & w;
      ALU_IOR:   res = a | w;
      ALU_XOR:   res = a ^ w;
      ALU_ASR:   {res, cOut} = {a[7], a};
      ALU_LSL:   {cOut, res} = {a, 1'b0};
      ALU_LSR:   {res, cOut} = {1'b0, a};
      ALU_RLC:   {cOut, res} = {a, cin};
      ALU_RRC:   {res, cOut} = {cin, a};
      ALU_INC:   res = a + 8'h01;
      ALU_DEC:   res = a - 8'h01;
      ALU_COM:   res = ~a;
      ALU_SWAP:  res = {a[3:0], a[7:4]};
      ALU_CLR:   res = 8'h00;
      ALU_PASSW: res = w;
      ALU_BCLR:  res = a & ~(8'h01 << bitSel);
      ALU_BSET:  res = a | (8'h01 << bitSel);
      default:   res = a;
    endcase
    if (op inside {ALU_ADD, ALU_ADDC, ALU_SUB, ALU_SUBB}) begin
      {cOut, dcOut, res} = s;
    end
    zOut = (res == 8'h00);
  end
endmodule // eid_alu

// ### design/eid_core.sv
/*
  Instruction decoder and execution control with an APB register slave.
  Assumes program memory answers progData combinationally from progAddr and
  that the APB master follows the usual setup/access sequence.
*/
`timescale 1ns/1ps
module eid_core import eid_pkg::*; #(
  parameter int MEM_AW = 9                       // data memory address width
) (
  input  wire logic            clk,              // 250 MHz core clock
  input  wire logic            reset_n,          // async reset, active low
  output logic      [PC_W-1:0] progAddr,         // instruction address
  input  wire logic [13:0]     progData,         // instruction word
  output logic      [7:0]      portADir,         // port a direction
  output logic      [7:0]      portBDir,         // port b direction
  output logic      [7:0]      portCDir,         // port c direction
  input  wire logic            psel,             // apb select
  input  wire logic            penable,          // apb enable
  input  wire logic            pwrite,           // apb direction
  input  wire logic [7:0]      paddr,            // apb byte address
  input  wire logic [31:0]     pwdata,           // apb write data
  output logic      [31:0]     prdata,           // apb read data
  output logic                 pready,           // apb ready
  output logic                 pslverr           // apb error
);
  // instruction fields
  wire logic [13:0] ir      = progData;
  wire logic [1:0]  pre     = ir[PRE_HI -: 2];
  wire logic [3:0]  opc     = ir[OPC_HI -: 4];
  wire logic        dBit    = ir[DEST_BIT];
  wire logic [6:0]  fAddr   = ir[6:0];
  wire logic [2:0]  bitSel  = ir[BITNUM_LO +: 3];
  wire logic [1:0]  bitOp   = ir[OPC_HI -: 2];       // two operation bits right under the prefix

  // architectural state
  logic [7:0]      acc;                          // working register
  logic            cFlag, dcFlag, zFlag;         // status flags
  logic [4:0]      bank_select_register;                          // bank select register
  logic [6:0]      pcLatch;                      // pc high latch
  logic [15:0]     ptr0, ptr1;                   // indirect pointers
  logic [PC_W-1:0] pc;                           // program counter
  eid_state_t      state;                        // sequencing state
  logic            flushAdvance;                 // flush cycle steps pc
  logic            run, stepPend;                // software run control

  // decode outputs
  eid_alu_op_t aluOp;
  logic useLit, fileAccess, wrFile, wrAcc;
  logic updC, updDc, updZ;
  logic skipOnZero, bitTest, bitTestSet;
  logic ldBank, ldLatch, ldDir;

  // decode of the current word; unknown words fall through as no-operation
  always_comb begin
    aluOp = ALU_MOV;
    useLit = 1'b0;
    fileAccess = 1'b0;
    wrFile = 1'b0;
    wrAcc = 1'b0;
    updC = 1'b0;
    updDc = 1'b0;
    updZ = 1'b0;
    skipOnZero = 1'b0;
    bitTest = 1'b0;
    bitTestSet = 1'b0;
    ldBank = 1'b0;
    ldLatch = 1'b0;
    ldDir = 1'b0;
    case (pre)
      PRE_BYTE: begin
        fileAccess = 1'b1;
        wrFile = dBit;
        wrAcc = !dBit;
        // flag selection by opcode set, so the operation select stays a plain enum assignment
        updC = opc inside {OP_ADD, OP_SUB, OP_RLC, OP_RRC};
        updDc = opc inside {OP_ADD, OP_SUB};
        updZ = opc inside {OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_INC,
                           OP_DEC, OP_COM, OP_MOV};
        skipOnZero = opc inside {OP_DECSZ, OP_INCSZ};
        case (opc)
          OP_MISC: begin                                   // store, bank, direction
            aluOp = ALU_PASSW;
            fileAccess = dBit;
            wrAcc = 1'b0;
            ldBank = (ir[7:5] == MISC_BANK);
            ldDir = (ir[7:3] == MISC_DIR) && (ir[2:0] >= DIR_A);
          end
          OP_CLR: begin
            aluOp = ALU_CLR;
            fileAccess = dBit;
            updZ = 1'b1;
          end
          OP_ADD: aluOp = ALU_ADD;
          OP_SUB: aluOp = ALU_SUB;
          OP_AND: aluOp = ALU_AND;
          OP_IOR: aluOp = ALU_IOR;
          OP_XOR: aluOp = ALU_XOR;
          OP_INC: aluOp = ALU_INC;
          OP_DEC: aluOp = ALU_DEC;
          OP_COM: aluOp = ALU_COM;
          OP_MOV: aluOp = ALU_MOV;
          OP_RLC: aluOp = ALU_RLC;
          OP_RRC: aluOp = ALU_RRC;
          OP_SWAP: aluOp = ALU_SWAP;
          OP_DECSZ: aluOp = ALU_DEC;
          OP_INCSZ: aluOp = ALU_INC;
          default: aluOp = ALU_MOV;
        endcase
      end
      PRE_BIT: begin
        fileAccess = 1'b1;
        aluOp = bitOp[0] ? ALU_BSET : ALU_BCLR;
        wrFile = !bitOp[1];
        bitTest = bitOp[1];
        bitTestSet = bitOp[0];
      end
      PRE_LIT: begin
        useLit = 1'b1;
        wrAcc = 1'b1;
        // literal flag sets; the extended byte ops below set their own flags
        updZ = opc inside {OPL_AND, OPL_IOR, OPL_XOR, OPL_SUB, OPL_ADD};
        updC = opc inside {OPL_SUB, OPL_ADD};
        updDc = opc inside {OPL_SUB, OPL_ADD};
        case (opc)
          OPX_ASR, OPX_LSL, OPX_LSR, OPX_SUBB, OPX_ADDC: begin
            useLit = 1'b0;
            fileAccess = 1'b1;
            wrFile = dBit;
            wrAcc = !dBit;
            updC = 1'b1;
            updZ = 1'b1;
            updDc = (opc == OPX_SUBB) || (opc == OPX_ADDC);
            case (opc)
              OPX_ASR: aluOp = ALU_ASR;
              OPX_LSL: aluOp = ALU_LSL;
              OPX_LSR: aluOp = ALU_LSR;
              OPX_SUBB: aluOp = ALU_SUBB;
              default: aluOp = ALU_ADDC;
            endcase
          end
          OPL_LOAD_LITERAL_TO_ACC: aluOp = ALU_MOV;
          OPL_LOAD_PC_HIGH_LATCH: begin
            wrAcc = 1'b0;
            ldLatch = ir[7];
          end
          OPL_AND: aluOp = ALU_AND;
          OPL_IOR: aluOp = ALU_IOR;
          OPL_XOR: aluOp = ALU_XOR;
          OPL_SUB: aluOp = ALU_SUB;
          OPL_ADD: aluOp = ALU_ADD;
          default: wrAcc = 1'b0;
        endcase
      end
      default: aluOp = ALU_MOV;                            // branch class not handled here
    endcase
  end

  // operand fetch: indirect slots, core registers, or banked memory
  wire logic        isInd     = fileAccess && (fAddr == FA_IND0 || fAddr == FA_IND1);
  wire logic [15:0] ptrSel    = fAddr[0] ? ptr1 : ptr0;
  wire logic        indHigh   = isInd && ptrSel[15];       // msb set: outside data space
  wire logic        specialHit = !isInd && (fAddr <= FA_PC_HIGH_LATCH);
  wire logic [11:0] directAddr = {bank_select_register, fAddr};
  wire logic [MEM_AW-1:0] memAddr = isInd ? ptrSel[MEM_AW-1:0] : directAddr[MEM_AW-1:0];
  wire logic [7:0]  statusByte = {3'h0, ST_TO_PD, zFlag, dcFlag, cFlag};
  logic [7:0] memRdata, specialVal, fileVal, aluRes;
  logic       aluC, aluDc, aluZ;

  // core register read mux
  always_comb begin
    case (fAddr)
      FA_PCL:    specialVal = pc[7:0];
      FA_STAT:   specialVal = statusByte;
      FA_P0L:    specialVal = ptr0[7:0];
      FA_P0H:    specialVal = ptr0[15:8];
      FA_P1L:    specialVal = ptr1[7:0];
      FA_P1H:    specialVal = ptr1[15:8];
      FA_BSR:    specialVal = {3'h0, bank_select_register};
      FA_ACC:    specialVal = acc;
      FA_PC_HIGH_LATCH: specialVal = {1'b0, pcLatch};
      default:   specialVal = 8'h00;
    endcase
  end

  // the high region is not modelled here: it reads zero and ignores writes
  assign fileVal = indHigh ? 8'h00 : (specialHit ? specialVal : memRdata);

  eid_alu u_alu (
    .op     (aluOp),
    .a      (useLit ? ir[7:0] : fileVal),
    .w      (acc),
    .cin    (cFlag),
    .bitSel (bitSel),
    .res    (aluRes),
    .cOut   (aluC),
    .dcOut  (aluDc),
    .zOut   (aluZ)
  );

  // execution timing
  wire logic go        = run || stepPend;
  wire logic commit    = go && ((state == S_EXEC && !indHigh) || state == S_IND_WAIT);
  wire logic bitMatch  = (fileVal[bitSel] == bitTestSet);
  wire logic skipTaken = commit && ((skipOnZero && aluZ) || (bitTest && bitMatch));
  wire logic fileWr    = commit && wrFile && fileAccess;
  wire logic coreWr    = fileWr && specialHit;
  wire logic pcWrite   = coreWr && fAddr == FA_PCL;
  wire logic statWr    = coreWr && fAddr == FA_STAT;
  wire logic memWe     = fileWr && !specialHit && !indHigh;

  eid_data_mem #(.AW(MEM_AW)) u_mem (
    .clk   (clk),
    .we    (memWe),
    .addr  (memAddr),
    .wdata (aluRes),
    .rdata (memRdata)
  );

  // sequencing: extra cycle for high indirect, no-op cycle after skip or pc write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_EXEC;
      pc <= '0;
      flushAdvance <= 1'b0;
    end else if (go) begin
      if (commit) begin
        state <= (skipTaken || pcWrite) ? S_FLUSH : S_EXEC;
        pc <= pcWrite ? {pcLatch, aluRes} : pc + 1'b1;
        flushAdvance <= !pcWrite;
      end else if (state == S_FLUSH) begin
        state <= S_EXEC;
        pc <= flushAdvance ? pc + 1'b1 : pc;
      end else begin
        state <= S_IND_WAIT;
      end
    end
  end

  // status flags: flag update beats a direct write of the status register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {zFlag, dcFlag, cFlag} <= 3'h0;
    end else begin
      cFlag <= (commit && updC) ? aluC : (statWr ? aluRes[ST_C] : cFlag);
      dcFlag <= (commit && updDc) ? aluDc : (statWr ? aluRes[ST_DC] : dcFlag);
      zFlag <= (commit && updZ) ? aluZ : (statWr ? aluRes[ST_Z] : zFlag);
    end
  end

  // working register and core registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc <= 8'h00;
      bank_select_register <= 5'h00;
      pcLatch <= 7'h00;
      ptr0 <= 16'h0000;
      ptr1 <= 16'h0000;
    end else begin
      if ((commit && wrAcc) || (coreWr && fAddr == FA_ACC)) acc <= aluRes;
      if (commit && ldBank) bank_select_register <= ir[4:0];
      else if (coreWr && fAddr == FA_BSR) bank_select_register <= aluRes[4:0];
      if (commit && ldLatch) pcLatch <= ir[6:0];
      else if (coreWr && fAddr == FA_PC_HIGH_LATCH) pcLatch <= aluRes[6:0];
      if (coreWr && fAddr == FA_P0L) ptr0[7:0] <= aluRes;
      if (coreWr && fAddr == FA_P0H) ptr0[15:8] <= aluRes;
      if (coreWr && fAddr == FA_P1L) ptr1[7:0] <= aluRes;
      if (coreWr && fAddr == FA_P1H) ptr1[15:8] <= aluRes;
    end
  end

  // direction registers, loaded from the working register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {portADir, portBDir, portCDir} <= {3{DIR_RST}};
    end else if (commit && ldDir) begin
      if (ir[2:0] == DIR_A) portADir <= acc;
      if (ir[2:0] == DIR_B) portBDir <= acc;
      if (ir[2:0] == DIR_C) portCDir <= acc;
    end
  end

  assign progAddr = pc;

  // apb slave: zero wait states, read data captured in the setup cycle
  wire logic apbSetup = psel && !penable;
  wire logic apbWr    = psel && penable && pwrite;
  wire logic mapped   = paddr inside {OFS_CTRL, OFS_STAT, OFS_ACC, OFS_PC, OFS_DIR, OFS_BANK};
  wire logic stepWr   = apbWr && paddr == OFS_CTRL && pwdata[CTRL_STEP];
  logic [31:0] readMux;

  always_comb begin
    case (paddr)
      OFS_CTRL: readMux = {31'h0, run};
      OFS_STAT: readMux = {24'h0, stepPend, 2'(state), statusByte[4:0]};
      OFS_ACC:  readMux = {24'h0, acc};
      OFS_PC:   readMux = {{(32-PC_W){1'b0}}, pc};
      OFS_DIR:  readMux = {8'h00, portCDir, portBDir, portADir};
      OFS_BANK: readMux = {17'h0, pcLatch, 3'h0, bank_select_register};
      default:  readMux = 32'h0;
    endcase
  end

  // run control; a new step request wins over the cycle that retires one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run <= 1'b0;
      stepPend <= 1'b0;
      prdata <= 32'h0;
    end else begin
      if (apbWr && paddr == OFS_CTRL) run <= pwdata[CTRL_RUN];
      stepPend <= stepWr || (stepPend && run);
      if (apbSetup && !pwrite) prdata <= readMux;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // checks
  a_addc_sum: assert property (@(posedge clk) disable iff (!reset_n)
    (commit && pre == PRE_LIT && opc == OPX_ADDC) |->
      {aluC, aluRes} == {1'b0, acc} + {1'b0, fileVal} + {8'h00, cFlag})
    else $error("add with carry sum wrong");
  a_xorlit_acc: assert property (@(posedge clk) disable iff (!reset_n)
    (commit && pre == PRE_LIT && opc == OPL_XOR) |=>
      acc == $past(acc ^ ir[7:0]) && zFlag == (acc == 8'h00))
    else $error("xor literal result or zero wrong");
  a_skip_flush: assert property (@(posedge clk) disable iff (!reset_n)
    (skipTaken && !pcWrite) |=> state == S_FLUSH ##1 (!go || (state == S_EXEC)))
    else $error("taken skip did not spend a no-op cycle");
  a_ind_stall: assert property (@(posedge clk) disable iff (!reset_n)
    (go && state == S_EXEC && indHigh) |-> !commit ##1 (state == S_IND_WAIT && $stable(pc)))
    else $error("high indirect access missed its extra cycle");
  a_bank_load: assert property (@(posedge clk) disable iff (!reset_n)
    (commit && ldBank) |=> bank_select_register == $past(ir[4:0]) && $stable(zFlag))
    else $error("bank select load wrong");
  a_dir_load: assert property (@(posedge clk) disable iff (!reset_n)
    (commit && ldDir && ir[2:0] == DIR_B) |=> portBDir == $past(acc) && $stable(portADir))
    else $error("direction register load wrong");
  a_swap_flags: assert property (@(posedge clk) disable iff (!reset_n)
    (commit && pre == PRE_BYTE && opc == OP_SWAP && fAddr != FA_STAT) |=>
      $stable({zFlag, dcFlag, cFlag}))
    else $error("nibble swap changed a flag");
  a_rot_carry: assert property (@(posedge clk) disable iff (!reset_n)
    (commit && pre == PRE_BYTE && opc == OP_RLC && fAddr != FA_STAT) |=>
      cFlag == $past(fileVal[7]) && $stable(zFlag))
    else $error("rotate left carry wrong");
endmodule // eid_core

// ### design/eid_data_mem.sv
/*
  Banked data memory behind the file-register space.
  Assumes read is asynchronous and write lands on the clock edge.
*/
`timescale 1ns/1ps
module eid_data_mem #(
  parameter int AW = 9                 // address width
) (
  input  wire logic          clk,      // core clock
  input  wire logic          we,       // write strobe
  input  wire logic [AW-1:0] addr,     // byte address
  input  wire logic [7:0]    wdata,    // write data
  output logic      [7:0]    rdata     // read data, same cycle
);
  logic [7:0] mem [0:(1<<AW)-1];       // contents are undefined after power-up

  // single write port, no reset so it maps onto ram
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  assign rdata = mem[addr];
endmodule // eid_data_mem

// ### design/eid_pkg.sv
/*
  Shared constants and types of the instruction decoder: opcode fields,
  file-register map, status bit positions, APB offsets and reset values.
  Assumes a 14-bit instruction word and an 8-bit data path.
*/
// What this block does
// - add-with-carry sums acc, file and carry
// - and/or/xor acc with file, zero only
// - arithmetic/logic shifts of file update carry, zero
// - rotate through carry touches carry only
// - subtract with borrow updates carry, digit, zero
// - inc/dec skip when zero, flags untouched
// - bit clear, set, and two bit tests
// - and/or/xor literal into acc, zero only
// - literal minus acc, literal plus acc
// - load pc high latch and bank select
// - taken skip or pc change costs two cycles
// - indirect pointer msb set adds one cycle
// - nibble swap to acc or file, no flags
// - xor literal writes acc, sets zero
// - direction load only for operands five to seven
// - xor acc with file to chosen destination
package eid_pkg;
  localparam int          PC_W      = 15;       // program counter width
  localparam int          PRE_HI    = 13;       // top bit of the 2-bit prefix
  localparam int          OPC_HI    = 11;       // top bit of the 4-bit opcode
  localparam int          DEST_BIT  = 7;        // destination select bit
  localparam int          BITNUM_LO = 7;        // lowest bit of the bit number
  localparam logic [1:0]  PRE_BYTE  = 2'h0;     // byte operations and misc
  localparam logic [1:0]  PRE_BIT   = 2'h1;     // bit operations
  localparam logic [1:0]  PRE_LIT   = 2'h3;     // literal and extended byte ops
  // byte opcodes under prefix 00
  localparam logic [3:0]  OP_MISC = 4'h0, OP_CLR = 4'h1, OP_SUB = 4'h2, OP_DEC = 4'h3;
  localparam logic [3:0]  OP_IOR  = 4'h4, OP_AND = 4'h5, OP_XOR = 4'h6, OP_ADD = 4'h7;
  localparam logic [3:0]  OP_MOV  = 4'h8, OP_COM = 4'h9, OP_INC = 4'ha, OP_DECSZ = 4'hb;
  localparam logic [3:0]  OP_RRC  = 4'hc, OP_RLC = 4'hd, OP_SWAP = 4'he, OP_INCSZ = 4'hf;
  // opcodes under prefix 11
  localparam logic [3:0]  OPX_LSL = 4'h5, OPX_LSR = 4'h6, OPX_ASR = 4'h7, OPX_SUBB = 4'hb;
  localparam logic [3:0]  OPX_ADDC = 4'hd;
  localparam logic [3:0]  OPL_LOAD_LITERAL_TO_ACC = 4'h0, OPL_LOAD_PC_HIGH_LATCH = 4'h1, OPL_IOR = 4'h8, OPL_AND = 4'h9;
  localparam logic [3:0]  OPL_XOR = 4'ha, OPL_SUB = 4'hc, OPL_ADD = 4'he;
  // misc group decode patterns on bits 7:3 of an opcode-0000 word
  localparam logic [2:0]  MISC_BANK = 3'h1;     // bits 7:5 = 001 bank load
  localparam logic [4:0]  MISC_DIR  = 5'h0c;    // bits 7:3 = 01100 direction load
  localparam logic [2:0]  DIR_A = 3'd5, DIR_B = 3'd6, DIR_C = 3'd7;
  // core file addresses, mirrored in every bank
  localparam logic [6:0]  FA_IND0 = 7'h00, FA_IND1 = 7'h01, FA_PCL = 7'h02, FA_STAT = 7'h03;
  localparam logic [6:0]  FA_P0L = 7'h04, FA_P0H = 7'h05, FA_P1L = 7'h06, FA_P1H = 7'h07;
  localparam logic [6:0]  FA_BSR = 7'h08, FA_ACC = 7'h09, FA_PC_HIGH_LATCH = 7'h0a;
  localparam int          ST_C = 0, ST_DC = 1, ST_Z = 2; // status bit positions
  localparam logic [1:0]  ST_TO_PD  = 2'h3;     // time-out, power-down read as set
  localparam logic [7:0]  DIR_RST   = 8'hff;    // port pins start as inputs
  // apb register byte offsets and control bits
  localparam logic [7:0]  OFS_CTRL = 8'h00, OFS_STAT = 8'h04, OFS_ACC = 8'h08;
  localparam logic [7:0]  OFS_PC = 8'h0c, OFS_DIR = 8'h10, OFS_BANK = 8'h14;
  localparam int          CTRL_RUN = 0, CTRL_STEP = 1;
  typedef enum logic [1:0] {S_EXEC, S_IND_WAIT, S_FLUSH} eid_state_t;
  typedef enum logic [4:0] {ALU_ADD, ALU_ADDC, ALU_SUB, ALU_SUBB, ALU_AND, ALU_IOR, ALU_XOR,
                            ALU_ASR, ALU_LSL, ALU_LSR, ALU_RLC, ALU_RRC, ALU_INC, ALU_DEC,
                            ALU_COM, ALU_MOV, ALU_SWAP, ALU_CLR, ALU_PASSW, ALU_BCLR,
                            ALU_BSET} eid_alu_op_t;
endpackage

// ### test/eid_prog_mem.sv
/*
  Program memory model: 32 instruction words, read without a clock.
  Assumes the bench loads every word before reset is released.
*/
`timescale 1ns/1ps
module eid_prog_mem import eid_pkg::*; (
  input  wire logic [PC_W-1:0] addr,  // fetch address
  output logic      [13:0]     data   // instruction word
);
  logic [13:0] words [0:31];          // loaded by the bench
  // past the loaded range fetch the no-op word
  assign data = (addr < PC_W'(32)) ? words[addr[4:0]] : 14'h0000;
endmodule // eid_prog_mem

// ### test/enhanced_8bit_instruction_decoder_tb.sv
/*
  Bench for eid_core: steps a short program over APB and checks results.
  Assumes zero-wait APB and a combinational program memory.
*/
`timescale 1ns/1ps
module enhanced_8bit_instruction_decoder_tb import eid_pkg::*;;
  logic            clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]      paddr, portADir, portBDir, portCDir;
  logic [31:0]     pwdata, prdata, r;
  logic [PC_W-1:0] progAddr;
  logic [13:0]     progData;
  logic            e;
  int              errCount = 0, totalChecks = 0;
  // load, xor, store, swap, dir, add | load, store, decsz, skipped, add | indirect |
  // bit set, bit test, skipped, load, add with carry, rotate, bit test, skipped, move, xor, shift, bank
  logic [13:0] prog [0:25] = '{14'h303c, 14'h3aff, 14'h00a0, 14'h0e20, 14'h0066, 14'h3ec4,
    14'h3001, 14'h00a1, 14'h0ba1, 14'h3055, 14'h3e01, 14'h3080, 14'h0085, 14'h0800,
    14'h15a1, 14'h1da1, 14'h3077, 14'h30f9, 14'h3d21, 14'h0da1, 14'h18a1, 14'h3033, 14'h0821,
    14'h06a0, 14'h3520, 14'h0023};
  eid_prog_mem pm (.addr(progAddr), .data(progData));
  eid_core dut (.clk(clk), .reset_n(reset_n), .progAddr(progAddr), .progData(progData),
    .portADir(portADir), .portBDir(portBDir), .portCDir(portCDir), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // only the watchdog ends a wait for ready
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  // single-step until the pc reaches pc, expecting exp steps
  task automatic step_to(input logic [PC_W-1:0] pc, input int exp);
    int n;
    n = 0;
    while (progAddr !== pc && n < 30) begin
      apb(1'b1, OFS_CTRL, 32'h2);
      repeat (2) @(posedge clk);
      n++;
    end
    chk(32'(n), 32'(exp));
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #40000;
    errCount++;
    finish_test;
  end
  initial begin
    reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    for (int i = 0; i < 32; i++) pm.words[i] = (i < 26) ? prog[i] : 14'h0000;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk(32'(portADir), 32'hff);
    chk(32'(portCDir), 32'hff);
    step_to(15'h6, 6);
    apb(1'b0, OFS_ACC, 32'h0);
    chk(r, 32'h00);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(r, 32'h1f);
    chk(32'(portBDir), 32'h3c);
    chk(32'(portADir), 32'hff);
    step_to(15'hb, 5);
    apb(1'b0, OFS_ACC, 32'h0);
    chk(r, 32'h02);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(r, 32'h18);
    step_to(15'he, 4);
    apb(1'b0, OFS_ACC, 32'h0);
    chk(r, 32'h00);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(r, 32'h1c);
    step_to(15'h1a, 12);
    apb(1'b0, OFS_ACC, 32'h0);
    chk(r, 32'ha4);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(r, 32'h1b);
    apb(1'b0, OFS_BANK, 32'h0);
    chk(r, 32'h03);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, e}, 32'h1);
    finish_test;
  end
endmodule // enhanced_8bit_instruction_decoder_tb
